// ### include/sbp_pkg.sv
// Shared constants, field positions and types for the serial port block
package sbp_pkg;
  localparam logic [7:0] SBP_PORT_BAUD   = 8'h78;
  localparam logic [7:0] SBP_PORT_DATA   = 8'h7C;
  localparam logic [7:0] SBP_PORT_STAT   = 8'h7D;
  localparam logic [7:0] SBP_RD_FLOAT    = 8'hFF;
  localparam logic [7:0] SBP_DIV_RESET   = 8'h0D;
  localparam logic [7:0] SBP_MODE_RESET  = 8'h00;
  localparam int         SBP_ST_TXRDY    = 0;
  localparam int         SBP_ST_RXRDY    = 1;
  localparam int         SBP_ST_TXEMPTY  = 2;
  localparam int         SBP_ST_PERR     = 3;
  localparam int         SBP_ST_OVERRUN  = 4;
  localparam int         SBP_ST_FERR     = 5;
  localparam int         SBP_ST_DSR      = 7;
  localparam int         SBP_CMD_TXEN    = 0;
  localparam int         SBP_CMD_DTR     = 1;
  localparam int         SBP_CMD_RXEN    = 2;
  localparam int         SBP_CMD_ERRRST  = 4;
  localparam int         SBP_CMD_RTS     = 5;
  localparam int         SBP_CMD_IRESET  = 6;
  localparam int         SBP_MODE_FACT   = 0;
  localparam int         SBP_MODE_LEN    = 2;
  localparam int         SBP_CH_CTRL     = 0;
  localparam int         SBP_CH_RESET    = 1;
  localparam int         SBP_CH_CONST    = 2;
  localparam logic [1:0] SBP_FACT_SYNC   = 2'h0;
  localparam logic [1:0] SBP_FACT_X1     = 2'h1;
  localparam logic [1:0] SBP_FACT_X16    = 2'h2;
  localparam logic [6:0] SBP_LEN_X1      = 7'h01;
  localparam logic [6:0] SBP_LEN_X16     = 7'h10;
  localparam logic [6:0] SBP_LEN_X64     = 7'h40;
  localparam int         SBP_FIFO_DEPTH  = 8;
  localparam int         SBP_DATA_W      = 8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } sbp_io_req_s;

  typedef enum logic       {SBP_INIT_MODE, SBP_INIT_CMD} sbp_init_e;
  typedef enum logic [1:0] {SBP_SER_IDLE, SBP_SER_START, SBP_SER_DATA, SBP_SER_STOP} sbp_ser_e;
endpackage

// ### test/sbp_term_model.sv
// Terminal model facing the serial lines of the serial port block
module sbp_term_model (
  input  wire logic clk_sys,
  input  wire logic txd,
  output logic      rxd,
  output logic      modemRx,
  output logic      modemTx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] syncPhase = 2'h0;
  logic       syncRun   = 1'b0;
  // Synchronous modem: free-running 1x clocks, four system cycles a bit
  always @(negedge clk_sys) syncPhase <= syncPhase + 2'h1;
  assign modemRx = syncRun && syncPhase[1];
  assign modemTx = syncRun && syncPhase[1];
  initial rxd = 1'b1;
  // One start bit, LSB first, one stop bit; badStop holds the stop bit low
  task automatic sendChar(input logic [7:0] c, input int bitCyc, input logic badStop);
    logic [9:0] frame;
    frame = {~badStop, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      rxd = frame[i];
      repeat (bitCyc - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    rxd = 1'b1;
    // Idle gap so a broken frame cannot run into the next one
    repeat (bitCyc) @(negedge clk_sys);
  endtask
  // Samples mid-bit; ok drops on a missing start, a bad stop or a timeout
  task automatic recvChar(input int bitCyc, output logic [7:0] c, output logic ok);
    int n;
    n = 0;
    c = 8'h00;
    while (txd !== 1'b0 && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    ok = (n < 40000);
    repeat (bitCyc / 2) @(negedge clk_sys);
    ok = ok && (txd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCyc) @(negedge clk_sys);
      c[i] = txd;
    end
    repeat (bitCyc) @(negedge clk_sys);
    ok = ok && (txd === 1'b1);
  endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the serial port block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbp_pkg::*;
  logic        clk_sys      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        ctsN         = 1'b0;
  logic        printerMode  = 1'b0;
  logic        printerReady = 1'b0;
  sbp_io_req_s ioReq        = '0;
  logic [7:0]  ioRdata;
  logic        txd, rtsN, dtrN, rxd, modemRx, modemTx;
  int          bad_count    = 0;
  int          tests_run    = 0;
  // Mode, divisor, character for each rate
  logic [23:0] rows [6] = '{24'h4ED0A5, 24'h4E683C, 24'h4E345A, 24'h4E1A81, 24'h4E0DC3, 24'h4F0D7E};
  logic [7:0]  gaps [3] = '{8'h79, 8'h7B, 8'h7E};

  always #50 clk_sys = ~clk_sys;

  sbp_serial_port u_sbp_serial_port (.ioReq(ioReq), .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .rxd(rxd),
    .ctsN(ctsN), .printerMode(printerMode), .printerReady(printerReady), .modem_receive_clock(modemRx),
    .modem_transmit_clock(modemTx), .ioRdata(ioRdata), .txd(txd), .rtsN(rtsN), .dtrN(dtrN));
  sbp_term_model u_sbp_term_model (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .modemRx(modemRx), .modemTx(modemTx));

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle strobes, launched on the falling edge
  task automatic ioWrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    ioReq = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    ioReq = '0;
  endtask
  task automatic ioRead(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    ioReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    ioReq = '0;
    d = ioRdata;
  endtask
  task automatic waitBit(input int b, input logic v);
    logic [7:0] s;
    int n;
    n = 0;
    s = {8{~v}};
    while (s[b] !== v) begin
      if (n++ > 5000) begin
        bad_count++;
        summarize();
      end
      ioRead(SBP_PORT_STAT, s);
    end
  endtask
  // Internal reset first, so the mode byte is taken as a mode byte
  task automatic setup(input logic [7:0] mode, input logic [7:0] div);
    ioWrite(SBP_PORT_STAT, 8'h40);
    ioWrite(SBP_PORT_STAT, mode);
    ioWrite(SBP_PORT_STAT, 8'h37);
    ioWrite(SBP_PORT_BAUD, 8'h45);
    ioWrite(SBP_PORT_BAUD, div);
  endtask
  task automatic getChar(input int bitCyc, input logic [7:0] exp);
    logic [7:0] c;
    logic ok;
    u_sbp_term_model.recvChar(bitCyc, c, ok);
    if (!ok) begin
      bad_count++;
      summarize();
    end
    check("serial out", c, exp);
  endtask
  function automatic int bitCycles(input logic [7:0] mode, input logic [7:0] div);
    int f;
    f = (mode[1:0] == 2'h3) ? 64 : (mode[1:0] == 2'h2) ? 16 : 1;
    return f * int'(div);
  endfunction

  initial begin
    logic [7:0] s;
    int n;
    int w;
    repeat (5) @(negedge clk_sys);
    check("reset read", ioRdata, SBP_RD_FLOAT);
    check("reset lines", {5'h00, txd, rtsN, dtrN}, 8'h07);
    @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (gaps[i]) begin
      ioRead(gaps[i], s);
      check("unmapped read", s, SBP_RD_FLOAT);
    end
    ioWrite(SBP_PORT_STAT, 8'h4E);
    ioWrite(SBP_PORT_STAT, 8'h37);
    ioWrite(SBP_PORT_BAUD, 8'h45);
    ioWrite(SBP_PORT_BAUD, SBP_DIV_RESET);
    check("modem lines", {6'h00, rtsN, dtrN}, 8'h00);
    ioRead(SBP_PORT_STAT, s);
    check("status idle", s, 8'h85);
    for (int k = 0; k < 3; k++) begin
      printerMode = (k != 0);
      printerReady = (k == 2);
      ioRead(SBP_PORT_STAT, s);
      check("ready input", {7'h00, s[SBP_ST_DSR]}, {7'h00, k != 1});
    end
    printerMode = 1'b0;
    // Every listed rate; reload keeps the clock running across frames
    foreach (rows[i]) begin
      setup(rows[i][23:16], rows[i][15:8]);
      ioWrite(SBP_PORT_DATA, rows[i][7:0]);
      getChar(bitCycles(rows[i][23:16], rows[i][15:8]), rows[i][7:0]);
    end
    setup(8'h4E, SBP_DIV_RESET);
    u_sbp_term_model.sendChar(8'h96, 208, 1'b0);
    waitBit(SBP_ST_RXRDY, 1'b1);
    ioRead(SBP_PORT_DATA, s);
    check("received char", s, 8'h96);
    ioRead(SBP_PORT_STAT, s);
    check("rx ready clear", {7'h00, s[SBP_ST_RXRDY]}, 8'h00);
    // Start-bit width timed through the ready input, as the firmware does
    fork
      u_sbp_term_model.sendChar(8'hFF, 208, 1'b0);
    join_none
    w = 0;
    n = 0;
    s = 8'hFF;
    while (s[SBP_ST_DSR] && w < 400) begin
      ioRead(SBP_PORT_STAT, s);
      w++;
    end
    while (!s[SBP_ST_DSR] && n < 400) begin
      ioRead(SBP_PORT_STAT, s);
      n++;
    end
    check("start width", 8'(n), 8'h68);
    wait fork;
    // Broken stop bit; gap lets any false start run out
    u_sbp_term_model.sendChar(8'h3C, 208, 1'b1);
    repeat (3000) @(negedge clk_sys);
    ioRead(SBP_PORT_STAT, s);
    check("framing flag", {7'h00, s[SBP_ST_FERR]}, 8'h01);
    ioWrite(SBP_PORT_STAT, 8'h37);
    ioRead(SBP_PORT_DATA, s);
    repeat (2) u_sbp_term_model.sendChar(8'h69, 208, 1'b0);
    ioRead(SBP_PORT_STAT, s);
    check("overrun flag", {7'h00, s[SBP_ST_OVERRUN]}, 8'h01);
    ioWrite(SBP_PORT_STAT, 8'h37);
    ioRead(SBP_PORT_STAT, s);
    check("errors cleared", {6'h00, s[SBP_ST_FERR], s[SBP_ST_OVERRUN]}, 8'h00);
    // Stalled far side: fill the buffer past full, then drain it
    setup(8'h4D, SBP_DIV_RESET);
    ctsN = 1'b1;
    for (int k = 0; k < 9; k++) ioWrite(SBP_PORT_DATA, 8'h10 + k[7:0]);
    ioRead(SBP_PORT_STAT, s);
    check("buffer full", {6'h00, s[SBP_ST_TXRDY], txd}, 8'h01);
    ctsN = 1'b0;
    for (int k = 0; k < 8; k++) getChar(13, 8'h10 + k[7:0]);
    waitBit(SBP_ST_TXEMPTY, 1'b1);
    // Synchronous mode: modem clocks pace the transmitter
    setup(8'h4C, SBP_DIV_RESET);
    u_sbp_term_model.syncRun = 1'b1;
    ioWrite(SBP_PORT_DATA, 8'hA6);
    getChar(4, 8'hA6);
    summarize();
  end
endmodule

// ### verilog/sbp_fifo.sv
// Transmit holding FIFO with valid/ready on both sides
module sbp_fifo #(
  parameter int WIDTH = sbp_pkg::SBP_DATA_W,
  parameter int DEPTH = sbp_pkg::SBP_FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  import sbp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      count;
  wire              push = ce && inValid && inReady;
  wire              pop  = ce && outValid && outReady;

  assign count    = wrPtr - rdPtr;
  assign inReady  = count != (AW + 1)'(DEPTH);
  assign outValid = count != '0;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop)  rdPtr <= rdPtr + 1'b1;
    end
  end

  chk_fifo_full_refuses: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (count == (AW + 1)'(DEPTH) && inValid && !pop) |=> count == $past(count)) else $error("fifo full took a write");
  chk_fifo_push_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (push && !pop) |=> count == $past(count) + 1'b1) else $error("fifo count missed a push");
endmodule

// ### verilog/sbp_serial_port.sv
// Serial port: baud divider channel, transceiver and host port decode
// How it works
// - Data at the lower port, status read and mode/command write at the upper.
// - Asynchronous and synchronous operation across the 150 to 9600 baud range.
// - A divider channel makes the transceiver clock at 1, 16 or 64 times baud, per the mode factor.
// - Factor 64 for the two slowest rates, factor 16 with listed divisors otherwise.
// - Status bit 1 is receive ready, bit 0 is transmit ready.
// - Ready-input reads receive line in terminal mode, printer ready otherwise.
// - The baud clock comes from the first counter channel.
module sbp_serial_port (
  input  wire sbp_pkg::sbp_io_req_s ioReq,
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                rxd,
  input  wire logic                ctsN,
  input  wire logic                printerMode,
  input  wire logic                printerReady,
  input  wire logic                modem_receive_clock,
  input  wire logic                modem_transmit_clock,
  output logic [7:0]               ioRdata,
  output logic                     txd,
  output logic                     rtsN,
  output logic                     dtrN
);
  import sbp_pkg::*;

  // Divider channel state
  logic [7:0] baudDiv;
  logic [7:0] baudCnt;
  logic       baudRun;
  logic       expectConst;
  logic       baudTick;

  // Transceiver configuration
  sbp_init_e  initSt;
  logic [7:0] mode;
  logic [7:0] cmd;

  // Receiver
  sbp_ser_e   rxSt;
  logic [6:0] rxCnt;
  logic [2:0] rxBit;
  logic [7:0] rxShift;
  logic [7:0] rxData;
  logic       rxRdy;
  logic       overrun;
  logic       frameErr;

  // Transmitter
  sbp_ser_e   txSt;
  logic [6:0] txCnt;
  logic [2:0] txBit;
  logic [7:0] txShift;
  logic       fifoInReady;
  logic       fifoOutValid;
  logic [7:0] fifoOutData;

  // Previous modem clock levels for edge detection
  logic       mrxPrev;
  logic       mtxPrev;

  wire       wrBaud    = ce && ioReq.wr && ioReq.addr == SBP_PORT_BAUD;
  wire       wrData    = ce && ioReq.wr && ioReq.addr == SBP_PORT_DATA;
  wire       wrStat    = ce && ioReq.wr && ioReq.addr == SBP_PORT_STAT;
  wire       rdData    = ce && ioReq.rd && ioReq.addr == SBP_PORT_DATA;
  wire       rdStat    = ce && ioReq.rd && ioReq.addr == SBP_PORT_STAT;
  wire       rdBaud    = ce && ioReq.rd && ioReq.addr == SBP_PORT_BAUD;
  wire [1:0] factor    = mode[SBP_MODE_FACT +: 2];
  wire [1:0] lenCode   = mode[SBP_MODE_LEN +: 2];
  wire       syncMode  = factor == SBP_FACT_SYNC;
  // Modem clocks replace the divider in synchronous mode
  wire       rxTick    = ce && (syncMode ? (modem_receive_clock && !mrxPrev) : baudTick);
  wire       txTick    = ce && (syncMode ? (modem_transmit_clock && !mtxPrev) : baudTick);
  // Ticks per bit from the mode factor; 64 gives the slow rates headroom
  wire [6:0] bitLen    = (syncMode || factor == SBP_FACT_X1) ? SBP_LEN_X1 :
                         (factor == SBP_FACT_X16) ? SBP_LEN_X16 : SBP_LEN_X64;
  wire [6:0] halfLen   = bitLen >> 1;
  wire [2:0] lastBit   = {1'b1, lenCode};
  wire       dsrLevel  = printerMode ? printerReady : rxd;
  wire       txRdy     = fifoInReady;
  wire       txEmpty   = txSt == SBP_SER_IDLE && !fifoOutValid;
  wire       rxDone    = rxTick && rxSt == SBP_SER_STOP && rxCnt == '0;
  wire       errClr    = wrStat && initSt == SBP_INIT_CMD && ioReq.data[SBP_CMD_ERRRST];
  // Load on a tick so the start bit lasts a full bit time, even at factor 1
  wire       txLoad    = txTick && txSt == SBP_SER_IDLE && cmd[SBP_CMD_TXEN] && !ctsN && fifoOutValid;
  wire [7:0] status    = {dsrLevel, 1'b0, frameErr, overrun, 1'b0, txEmpty, rxRdy, txRdy};
  wire [7:0] next_rd   = rdData ? rxData : rdStat ? status : rdBaud ? baudCnt : SBP_RD_FLOAT;

  assign baudTick = ce && baudRun && baudCnt == 8'h01;

  // Divider channel: control word, then constant; reloads at terminal count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baudDiv     <= SBP_DIV_RESET;
      baudCnt     <= SBP_DIV_RESET;
      baudRun     <= 1'b0;
      expectConst <= 1'b0;
    end else if (wrBaud && expectConst) begin
      baudDiv     <= ioReq.data;
      baudCnt     <= ioReq.data;
      baudRun     <= 1'b1;
      expectConst <= 1'b0;
    end else if (wrBaud && ioReq.data[SBP_CH_CTRL]) begin
      expectConst <= ioReq.data[SBP_CH_CONST];
      baudRun     <= baudRun && !ioReq.data[SBP_CH_RESET];
    end else if (baudTick) begin
      baudCnt     <= baudDiv;
    end else if (ce && baudRun) begin
      baudCnt     <= baudCnt - 8'h01;
    end
  end

  // Mode byte first after reset, command bytes after that
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      initSt <= SBP_INIT_MODE;
      mode   <= SBP_MODE_RESET;
      cmd    <= '0;
      rtsN   <= 1'b1;
      dtrN   <= 1'b1;
    end else if (wrStat && initSt == SBP_INIT_MODE) begin
      mode   <= ioReq.data;
      initSt <= SBP_INIT_CMD;
    end else if (wrStat) begin
      cmd    <= ioReq.data[SBP_CMD_IRESET] ? '0 : ioReq.data;
      initSt <= ioReq.data[SBP_CMD_IRESET] ? SBP_INIT_MODE : SBP_INIT_CMD;
      rtsN   <= ioReq.data[SBP_CMD_IRESET] || !ioReq.data[SBP_CMD_RTS];
      dtrN   <= ioReq.data[SBP_CMD_IRESET] || !ioReq.data[SBP_CMD_DTR];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ioRdata <= SBP_RD_FLOAT;
      mrxPrev <= 1'b0;
      mtxPrev <= 1'b0;
    end else if (ce) begin
      ioRdata <= (ioReq.rd) ? next_rd : ioRdata;
      mrxPrev <= modem_receive_clock;
      mtxPrev <= modem_transmit_clock;
    end
  end

  // Receiver: start bit checked at mid point at factors 16 and 64, a whole bit after detection at factor 1 and in sync; then one sample per bit time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxSt    <= SBP_SER_IDLE;
      rxCnt   <= '0;
      rxBit   <= '0;
      rxShift <= '0;
    end else if (rxTick) begin
      unique case (rxSt)
        SBP_SER_IDLE: begin
          if (cmd[SBP_CMD_RXEN] && !rxd) begin
            rxSt  <= SBP_SER_START;
            rxCnt <= halfLen;
          end
        end
        SBP_SER_START: begin
          if (rxCnt != '0) begin
            rxCnt <= rxCnt - 7'h01;
          end else begin
            rxSt  <= rxd ? SBP_SER_IDLE : SBP_SER_DATA;
            rxCnt <= bitLen - 7'h01;
            rxBit <= '0;
          end
        end
        SBP_SER_DATA: begin
          if (rxCnt != '0) begin
            rxCnt <= rxCnt - 7'h01;
          end else begin
            rxShift <= {rxd, rxShift[7:1]};
            rxCnt   <= bitLen - 7'h01;
            rxBit   <= rxBit + 3'h1;
            rxSt    <= (rxBit == lastBit) ? SBP_SER_STOP : SBP_SER_DATA;
          end
        end
        SBP_SER_STOP: begin
          if (rxCnt != '0) rxCnt <= rxCnt - 7'h01;
          else rxSt <= SBP_SER_IDLE;
        end
      endcase
    end
  end

  // Receive flags: a completed character wins over a clearing read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxData   <= '0;
      rxRdy    <= 1'b0;
      overrun  <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      if (rxDone) rxData <= rxShift >> (2'h3 - lenCode);
      rxRdy    <= rxDone || (rxRdy && !rdData);
      overrun  <= (rxDone && rxRdy && !rdData) || (overrun && !errClr);
      frameErr <= (rxDone && !rxd) || (frameErr && !errClr);
    end
  end

  // Transmitter: start, data bits LSB first, one stop bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txSt    <= SBP_SER_IDLE;
      txCnt   <= '0;
      txBit   <= '0;
      txShift <= '0;
      txd     <= 1'b1;
    end else if (txLoad) begin
      txSt    <= SBP_SER_START;
      txShift <= fifoOutData;
      txCnt   <= bitLen - 7'h01;
      txd     <= 1'b0;
    end else if (txTick && txSt != SBP_SER_IDLE) begin
      if (txCnt != '0) begin
        txCnt <= txCnt - 7'h01;
      end else begin
        txCnt <= bitLen - 7'h01;
        unique case (txSt)
          SBP_SER_START: begin
            txSt    <= SBP_SER_DATA;
            txd     <= txShift[0];
            txShift <= txShift >> 1;
            txBit   <= '0;
          end
          SBP_SER_DATA: begin
            txSt    <= (txBit == lastBit) ? SBP_SER_STOP : SBP_SER_DATA;
            txd     <= (txBit == lastBit) ? 1'b1 : txShift[0];
            txShift <= txShift >> 1;
            txBit   <= txBit + 3'h1;
          end
          SBP_SER_STOP: begin
            txSt <= SBP_SER_IDLE;
          end
          SBP_SER_IDLE: begin
            txSt <= SBP_SER_IDLE;
          end
        endcase
      end
    end
  end

  // Host writes to a full FIFO are dropped; the transmit ready bit shows it is full
  sbp_fifo #(
    .WIDTH (SBP_DATA_W),
    .DEPTH (SBP_FIFO_DEPTH)
  ) u_txFifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .inValid  (wrData),
    .inReady  (fifoInReady),
    .inData   (ioReq.data),
    .outValid (fifoOutValid),
    .outReady (txLoad),
    .outData  (fifoOutData)
  );

  sequence statRead;
    rdStat;
  endsequence

  sequence modeThenCmd;
    (wrStat && initSt == SBP_INIT_MODE) ##1 (initSt == SBP_INIT_CMD);
  endsequence

  chk_baud_reload_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    baudTick |=> baudCnt == $past(baudDiv)) else $error("divider did not reload");
  chk_baud_tick_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ce && baudRun && baudCnt == 8'h02 && !wrBaud) |=> baudTick || !ce) else $error("missed terminal count");
  chk_status_rx_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    statRead |=> ioRdata[SBP_ST_RXRDY] == $past(rxRdy)) else $error("rx ready bit wrong");
  chk_status_tx_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    statRead |=> ioRdata[SBP_ST_TXRDY] == $past(fifoInReady)) else $error("tx ready bit wrong");
  chk_data_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rdData && !rxDone) |=> !rxRdy ##0 ioRdata == $past(rxData)) else $error("data read mishandled");
  chk_mode_cmd_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wrStat && initSt == SBP_INIT_MODE) |-> modeThenCmd) else $error("mode byte not followed by command");
  chk_dsr_terminal_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (statRead and !printerMode) |=> ioRdata[SBP_ST_DSR] == $past(rxd)) else $error("ready input source wrong");
  chk_tx_frame_levels: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (txSt == SBP_SER_START |-> !txd) and (txSt == SBP_SER_STOP |-> txd)) else $error("tx frame level wrong");
endmodule
